// *** rtl/pcsr_regs.sv ***
`timescale 1ns/1ps

module pcsr_regs
    import pcsr_pkg::*;
#(
    parameter bit ONE_WAY_CAP = 1'b1
)
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic link_ok_in,
    input wire logic an_done_in,
    input wire logic reduced_tbi_in,
    output logic tx_allow_out,
    output logic an_enable_out,
    output logic an_restart_out,
    output logic isolate_out,
    output logic powerdown_out,
    output logic loopback_out,
    output logic sm_reset_out,
    output logic ability_valid_out,
    output logic irq_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic uni_q, uni_d;
    logic restart_q, restart_d;
    logic isolate_q, isolate_d;
    logic pwrdn_q, pwrdn_d;
    logic an_en_q, an_en_d;
    logic loop_q, loop_d;
    logic rst_bit_q, rst_bit_d;
    logic link_latch_q, link_latch_d;
    logic link_prev_q, link_prev_d;
    logic an_cmpl_q, an_cmpl_d;
    logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
    logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic tx_allow_q, tx_allow_d;
    logic restart_pls_q, restart_pls_d;
    logic sm_rst_q, sm_rst_d;
    logic loop_out_q, loop_out_d;
    logic abil_q, abil_d;
    logic irq_q, irq_d;

    logic [9:0] idx;
    logic hit_ctrl, hit_stat, hit_istat, hit_imask, mapped;
    logic setup, wr_en, rd_en, lo_lane, hi_lane;
    logic [15:0] ctrl_word, stat_word;
    logic [IRQ_W-1:0] events;

    // ------------------------------------------------------------
    // Address decode and transfer phases
    // ------------------------------------------------------------
    // Misaligned byte addresses fall into the unmapped set on purpose
    assign idx = paddr_in[IDX_LSB+9:IDX_LSB];
    assign hit_ctrl = (idx == IDX_CTRL) && (paddr_in[IDX_LSB-1:0] == '0);
    assign hit_stat = (idx == IDX_STAT) && (paddr_in[IDX_LSB-1:0] == '0);
    assign hit_istat = (idx == IDX_IRQ_STAT) && (paddr_in[IDX_LSB-1:0] == '0);
    assign hit_imask = (idx == IDX_IRQ_MASK) && (paddr_in[IDX_LSB-1:0] == '0);
    assign mapped = hit_ctrl | hit_stat | hit_istat | hit_imask;
    assign setup = psel_in & ~penable_in & ~pready_q;
    assign wr_en = psel_in & penable_in & pready_q & pwrite_in & mapped;
    assign rd_en = psel_in & penable_in & pready_q & ~pwrite_in;
    assign lo_lane = pstrb_in[0];
    assign hi_lane = pstrb_in[1];

    // ------------------------------------------------------------
    // Readback words
    // ------------------------------------------------------------
    // Fixed fields are constants, so writes to them can never stick
    always_comb
    begin
        ctrl_word = WORD_ZERO;
        ctrl_word[C_UNI] = uni_q;
        ctrl_word[C_RATE_LO] = RATE_LO_VAL;
        ctrl_word[C_RATE_HI] = RATE_HI_VAL;
        ctrl_word[C_COL_TEST] = COL_TEST_VAL;
        ctrl_word[C_DUPLEX] = DUPLEX_VAL;
        ctrl_word[C_RESTART] = restart_q;
        ctrl_word[C_ISOLATE] = isolate_q;
        ctrl_word[C_PWRDN] = pwrdn_q;
        ctrl_word[C_AN_EN] = an_en_q;
        ctrl_word[C_LOOP] = loop_q;
        ctrl_word[C_RESET] = rst_bit_q;
        // Unused status positions stay at the zero default
        stat_word = WORD_ZERO;
        stat_word[S_EXT] = 1'b1;
        stat_word[S_AN_ABIL] = 1'b1;
        stat_word[S_LINK] = link_latch_q;
        stat_word[S_AN_DONE] = an_cmpl_q;
        stat_word[S_ONE_WAY] = ONE_WAY_CAP;
    end

    // Edge events from the link and negotiation inputs
    always_comb
    begin
        events = '0;
        events[E_LINK_LOST] = link_prev_q & ~link_ok_in;
        events[E_LINK_UP] = ~link_prev_q & link_ok_in;
        events[E_AN_DONE] = an_cmpl_d & ~an_cmpl_q;
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        uni_d = uni_q;
        restart_d = restart_q;
        isolate_d = isolate_q;
        pwrdn_d = pwrdn_q;
        an_en_d = an_en_q;
        loop_d = loop_q;
        irq_mask_d = irq_mask_q;
        restart_pls_d = 1'b0;
        // Self-clearing: a set reset bit lives exactly one cycle
        rst_bit_d = 1'b0;
        prdata_d = prdata_q;
        pready_d = setup;
        pslverr_d = setup & ~mapped;
        if (setup)
        begin
            prdata_d = DATA_ZERO;
            if (!pwrite_in)
            begin
                unique case (1'b1)
                    hit_ctrl: prdata_d[15:0] = ctrl_word;
                    hit_stat: prdata_d[15:0] = stat_word;
                    hit_istat: prdata_d[IRQ_W-1:0] = irq_stat_q;
                    hit_imask: prdata_d[IRQ_W-1:0] = irq_mask_q;
                    default: prdata_d = DATA_ZERO;
                endcase
            end
        end
        if (wr_en && hit_ctrl && lo_lane)
        begin
            uni_d = pwdata_in[C_UNI];
        end
        if (wr_en && hit_ctrl && hi_lane)
        begin
            restart_d = pwdata_in[C_RESTART];
            restart_pls_d = pwdata_in[C_RESTART];
            isolate_d = pwdata_in[C_ISOLATE];
            pwrdn_d = pwdata_in[C_PWRDN];
            an_en_d = pwdata_in[C_AN_EN];
            loop_d = pwdata_in[C_LOOP];
            rst_bit_d = pwdata_in[C_RESET];
        end
        if (wr_en && hit_imask && lo_lane)
        begin
            irq_mask_d = pwdata_in[IRQ_W-1:0];
        end
        // Event beats the write-one clear in the same cycle
        irq_stat_d = irq_stat_q;
        if (wr_en && hit_istat && lo_lane)
        begin
            irq_stat_d = irq_stat_q & ~pwdata_in[IRQ_W-1:0];
        end
        irq_stat_d = irq_stat_d | events;
        // Latch-low link: a read reloads the live level
        if (rd_en && hit_stat)
        begin
            link_latch_d = link_ok_in;
        end
        else
        begin
            link_latch_d = link_latch_q & link_ok_in;
        end
        link_prev_d = link_ok_in;
        // Completion drops on restart or reset so stale abilities are not trusted
        an_cmpl_d = an_done_in & an_en_q & ~restart_pls_q & ~sm_rst_q;
        // Unidirectional bit only counts with negotiation off
        tx_allow_d = link_ok_in | (~an_en_q & uni_q);
        sm_rst_d = rst_bit_q;
        loop_out_d = loop_q & ~reduced_tbi_in;
        abil_d = an_cmpl_q;
        irq_d = |(irq_stat_q & irq_mask_q);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            uni_q <= 1'b0;
            restart_q <= 1'b0;
            isolate_q <= 1'b0;
            pwrdn_q <= 1'b0;
            an_en_q <= CTRL_AN_EN_RST;
            loop_q <= 1'b0;
            rst_bit_q <= 1'b0;
            link_latch_q <= 1'b0;
            link_prev_q <= 1'b0;
            an_cmpl_q <= 1'b0;
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            prdata_q <= DATA_ZERO;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            tx_allow_q <= 1'b0;
            restart_pls_q <= 1'b0;
            sm_rst_q <= 1'b0;
            loop_out_q <= 1'b0;
            abil_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            uni_q <= uni_d;
            restart_q <= restart_d;
            isolate_q <= isolate_d;
            pwrdn_q <= pwrdn_d;
            an_en_q <= an_en_d;
            loop_q <= loop_d;
            rst_bit_q <= rst_bit_d;
            link_latch_q <= link_latch_d;
            link_prev_q <= link_prev_d;
            an_cmpl_q <= an_cmpl_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            tx_allow_q <= tx_allow_d;
            restart_pls_q <= restart_pls_d;
            sm_rst_q <= sm_rst_d;
            loop_out_q <= loop_out_d;
            abil_q <= abil_d;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------
    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign tx_allow_out = tx_allow_q;
    assign an_enable_out = an_en_q;
    assign an_restart_out = restart_pls_q;
    assign isolate_out = isolate_q;
    assign powerdown_out = pwrdn_q;
    assign loopback_out = loop_out_q;
    assign sm_reset_out = sm_rst_q;
    assign ability_valid_out = abil_q;
    assign irq_out = irq_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    logic ctrl_hi_wr;
    assign ctrl_hi_wr = wr_en & hit_ctrl & hi_lane;

    sequence s_reset_write;
        ctrl_hi_wr && pwdata_in[C_RESET];
    endsequence

    sequence s_one_pulse;
        !sm_reset_out ##1 sm_reset_out ##1 !sm_reset_out;
    endsequence

    a_an_ignores_uni: assert property ((an_en_q && uni_q && !link_ok_in) |=> !tx_allow_out)
        else $error("tx allowed without link while negotiating");

    a_uni_tx_free: assert property ((!an_en_q && uni_q) |=> tx_allow_out)
        else $error("unidirectional transmit not allowed");

    a_ctrl_fixed_bits: assert property ((setup && !pwrite_in && hit_ctrl) |=>
        (prdata_out[C_RATE_LO] && !prdata_out[C_RATE_HI] && !prdata_out[C_COL_TEST] && prdata_out[C_DUPLEX]))
        else $error("control fixed bits wrong");

    a_restart_pulse: assert property ((ctrl_hi_wr && pwdata_in[C_RESTART]) |=> an_restart_out ##1
        (!an_restart_out || $past(ctrl_hi_wr && pwdata_in[C_RESTART])))
        else $error("restart pulse wrong");

    a_isolate_follow: assert property (ctrl_hi_wr |=> (isolate_out == $past(pwdata_in[C_ISOLATE])))
        else $error("isolate not following write");

    a_pwrdn_follow: assert property (ctrl_hi_wr |=> (powerdown_out == $past(pwdata_in[C_PWRDN])))
        else $error("power-down not following write");

    a_loop_reduced_tbi: assert property (reduced_tbi_in |=> !loopback_out)
        else $error("loopback active with reduced tbi");

    // Pulse shows two edges after the write edge, so the check starts one edge later
    a_reset_one_pulse: assert property ((s_reset_write ##1 !ctrl_hi_wr) |-> s_one_pulse)
        else $error("reset pulse not single");

    a_status_fixed: assert property ((setup && !pwrite_in && hit_stat) |=>
        (prdata_out[S_EXT] && prdata_out[S_AN_ABIL] && prdata_out[15:8] == '0 && !prdata_out[1]
        && !prdata_out[4] && !prdata_out[6]))
        else $error("status fixed bits wrong");

    a_link_latch_low: assert property ((!link_ok_in) ##1 (link_ok_in && !(rd_en && hit_stat)) [*2] |->
        !link_latch_q)
        else $error("link loss not latched");

    a_abil_valid: assert property (ability_valid_out |-> $past(an_cmpl_q))
        else $error("abilities flagged valid early");

    a_irq_level: assert property ((irq_stat_q & irq_mask_q) != '0 |=> irq_out)
        else $error("interrupt not raised");

endmodule // pcsr_regs

// *** rtl/pcsr_pkg.sv ***
package pcsr_pkg;

    // ------------------------------------------------------------
    // Register map: printed indices, byte address is four times
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_CTRL = 10'h000;
    localparam logic [9:0] IDX_STAT = 10'h001;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h020;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h021;
    localparam int IDX_LSB = 2;

    // ------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------
    localparam int C_UNI = 5;
    localparam int C_RATE_LO = 6;
    localparam int C_COL_TEST = 7;
    localparam int C_DUPLEX = 8;
    localparam int C_RESTART = 9;
    localparam int C_ISOLATE = 10;
    localparam int C_PWRDN = 11;
    localparam int C_AN_EN = 12;
    localparam int C_RATE_HI = 13;
    localparam int C_LOOP = 14;
    localparam int C_RESET = 15;
    localparam logic CTRL_AN_EN_RST = 1'b1;

    // Gigabit rate code, bit 6 high and bit 13 low
    localparam logic RATE_LO_VAL = 1'b1;
    localparam logic RATE_HI_VAL = 1'b0;
    localparam logic COL_TEST_VAL = 1'b0;
    localparam logic DUPLEX_VAL = 1'b1;

    // ------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------
    localparam int S_EXT = 0;
    localparam int S_LINK = 2;
    localparam int S_AN_ABIL = 3;
    localparam int S_AN_DONE = 5;
    localparam int S_ONE_WAY = 7;

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    localparam int IRQ_W = 3;
    localparam int E_LINK_LOST = 0;
    localparam int E_AN_DONE = 1;
    localparam int E_LINK_UP = 2;

    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage : pcsr_pkg

// *** sim/pcsr_mac_model.sv ***
`timescale 1ns/1ps

// ------------------------------
// Link and negotiation far side
// ------------------------------
module pcsr_mac_model #(
    parameter int AN_DELAY = 20
)
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic drop_in,
    input wire logic an_enable_in,
    input wire logic an_restart_in,
    input wire logic sm_reset_in,
    output logic link_ok_out,
    output logic an_done_out
);
    int cnt_q;
    int cnt_d;
    logic link_q;
    logic link_d;

    // Negotiation starts over on any restart or reset pulse
    always_comb
    begin
        cnt_d = (cnt_q < AN_DELAY) ? cnt_q + 1 : cnt_q;
        if (srst_in || an_restart_in || sm_reset_in || !an_enable_in)
            cnt_d = 0;
        link_d = !drop_in;
    end

    // Registered, so a link drop never lands in the edge that asked for it
    always_ff @(posedge clk_in)
    begin
        cnt_q <= cnt_d;
        link_q <= link_d;
    end
    assign link_ok_out = link_q;
    assign an_done_out = (cnt_q == AN_DELAY);
endmodule // pcsr_mac_model

// *** sim/test_pcs_control_status_regs.sv ***
`timescale 1ns/1ps

module test_pcs_control_status_regs
    import pcsr_pkg::*;
;
    // ------------------------------
    // Signals and expected state
    // ------------------------------
    localparam bit ONE_WAY = 1'b1;
    localparam logic [ADDR_W-1:0] A_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] A_STAT = {IDX_STAT, 2'b00};
    localparam logic [ADDR_W-1:0] A_IST = {IDX_IRQ_STAT, 2'b00};
    localparam logic [ADDR_W-1:0] A_IMK = {IDX_IRQ_MASK, 2'b00};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reduced_tbi = 1'b0, drop = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = DATA_ZERO;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, link_ok, an_done, tx_allow, an_en, an_rst, iso, pwd, loop, sm_rst, ab_valid, irq, err;
    logic [15:0] ctrl, v;
    logic [3:0] s;
    logic [ADDR_W-1:0] bad [3] = '{12'h008, 12'h002, 12'h0FC};
    int fails = 0;
    int n_tests = 0;
    int seed = 60;
    int c_rst, c_sm;

    // Bus clock, 50 ns period
    always #25 clk = ~clk;

    pcsr_regs #(.ONE_WAY_CAP(ONE_WAY)) i_pcsr_regs (.clk_in(clk), .srst_in(srst), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link_ok_in(link_ok),
        .an_done_in(an_done), .reduced_tbi_in(reduced_tbi), .tx_allow_out(tx_allow), .an_enable_out(an_en),
        .an_restart_out(an_rst), .isolate_out(iso), .powerdown_out(pwd), .loopback_out(loop),
        .sm_reset_out(sm_rst), .ability_valid_out(ab_valid), .irq_out(irq));

    pcsr_mac_model i_pcsr_mac_model (.clk_in(clk), .srst_in(srst), .drop_in(drop), .an_enable_in(an_en),
        .an_restart_in(an_rst), .sm_reset_in(sm_rst), .link_ok_out(link_ok), .an_done_out(an_done));

    // ------------------------------
    // Bus cycles and comparisons
    // ------------------------------
    // Request stands from setup until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] st);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        // Answer taken at the same edge that sees pready high
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20)
        begin
            fails++;
            $display("unexpected pready: expected 1, seen none");
        end
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Control write; the model follows the byte strobes
    task automatic wctl(input logic [15:0] val, input logic [3:0] st);
        logic [15:0] m;
        m = {{8{st[1]}}, {8{st[0]}}};
        apb(1'b1, A_CTRL, {16'h0000, val}, st);
        ctrl = (ctrl & ~m) | (val & m);
    endtask

    task automatic count_pulses();
        c_rst = 0;
        c_sm = 0;
        repeat (5)
        begin
            @(negedge clk);
            c_rst += int'(an_rst === 1'b1);
            c_sm += int'(sm_rst === 1'b1);
        end
    endtask

    // Writable bits kept, rate/duplex fixed, reset bit never stored
    function automatic logic [31:0] exp_ctrl(input logic [15:0] c);
        return {16'h0000, (c & 16'h5E20) | 16'h0140};
    endfunction

    function automatic logic [31:0] exp_stat(input logic lk, input logic dn);
        return {24'h00_0000, ONE_WAY, 1'b0, dn, 1'b0, 1'b1, lk, 1'b0, 1'b1};
    endfunction

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles needed
    initial
    begin
        #2_000_000;
        fails++;
        $display("unexpected run length: expected end, seen timeout");
        complete_run();
    end

    // ------------------------------
    // Scenarios
    // ------------------------------
    initial
    begin
        ctrl = 16'h1000;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, A_CTRL, DATA_ZERO, 4'h0);
        chk("ctrl", exp_ctrl(ctrl), rd);
        chk("pslverr", 1'h0, err);
        repeat (30) @(posedge clk);
        apb(1'b0, A_STAT, DATA_ZERO, 4'h0);
        chk("status", exp_stat(1'b0, 1'b1), rd);
        apb(1'b0, A_STAT, DATA_ZERO, 4'h0);
        chk("status", exp_stat(1'b1, 1'b1), rd);
        // Link loss raises an event; only the masked one reaches irq_out
        apb(1'b1, A_IST, 32'h0000_0007, 4'hF);
        apb(1'b1, A_IMK, 32'h0000_0001, 4'hF);
        drop <= 1'b1;
        repeat (3) @(posedge clk);
        drop <= 1'b0;
        repeat (4) @(posedge clk);
        chk("irq_out", 1'h1, irq);
        apb(1'b0, A_IST, DATA_ZERO, 4'h0);
        chk("irq status", 32'h0000_0005, rd);
        apb(1'b0, A_STAT, DATA_ZERO, 4'h0);
        chk("status", exp_stat(1'b0, 1'b1), rd);
        apb(1'b0, A_STAT, DATA_ZERO, 4'h0);
        chk("status", exp_stat(1'b1, 1'b1), rd);
        apb(1'b1, A_IST, 32'h0000_0001, 4'hF);
        repeat (2) @(posedge clk);
        chk("irq_out", 1'h0, irq);
        apb(1'b0, A_IST, DATA_ZERO, 4'h0);
        chk("irq status", 32'h0000_0004, rd);
        // Random control words, strobes, link state and interface mode
        repeat (16)
        begin
            v = 16'($random(seed)) & 16'h7FFF;
            s = 4'($random(seed)) & 4'h3;
            drop <= 1'($random(seed));
            reduced_tbi <= 1'($random(seed));
            wctl(v, s);
            repeat (3) @(negedge clk);
            chk("isolate_out", ctrl[10], iso);
            chk("powerdown_out", ctrl[11], pwd);
            chk("an_enable_out", ctrl[12], an_en);
            chk("loopback_out", ctrl[14] & !reduced_tbi, loop);
            chk("tx_allow_out", !drop | (!ctrl[12] & ctrl[5]), tx_allow);
            apb(1'b0, A_CTRL, DATA_ZERO, 4'h0);
            chk("ctrl", exp_ctrl(ctrl), rd);
        end
        drop <= 1'b0;
        // Restart pulse and negotiation completion
        wctl(16'h1000, 4'h3);
        repeat (30) @(posedge clk);
        apb(1'b0, A_STAT, DATA_ZERO, 4'h0);
        chk("an done", 1'h1, rd[S_AN_DONE]);
        chk("ability_valid_out", 1'h1, ab_valid);
        wctl(16'h1200, 4'h3);
        count_pulses();
        chk("restart pulses", 32'd1, c_rst);
        apb(1'b0, A_STAT, DATA_ZERO, 4'h0);
        chk("an done", 1'h0, rd[S_AN_DONE]);
        chk("ability_valid_out", 1'h0, ab_valid);
        // Reset bit pulses once, clears itself, needs its byte lane
        wctl(16'h9000, 4'h3);
        count_pulses();
        chk("reset pulses", 32'd1, c_sm);
        apb(1'b0, A_CTRL, DATA_ZERO, 4'h0);
        chk("ctrl", exp_ctrl(ctrl), rd);
        wctl(16'h8000, 4'h1);
        count_pulses();
        chk("reset pulses", 32'd0, c_sm);
        // Negotiation off: never complete
        wctl(16'h0000, 4'h3);
        repeat (30) @(posedge clk);
        apb(1'b1, A_STAT, 32'hFFFF_FFFF, 4'hF);
        apb(1'b0, A_STAT, DATA_ZERO, 4'h0);
        chk("status", exp_stat(1'b1, 1'b0), rd);
        chk("ability_valid_out", 1'h0, ab_valid);
        // Unmapped and misaligned places refuse and leave state alone
        foreach (bad[i])
        begin
            apb(1'b1, bad[i], 32'hFFFF_FFFF, 4'hF);
            chk("pslverr", 1'h1, err);
            apb(1'b0, bad[i], DATA_ZERO, 4'h0);
            chk("rdata", DATA_ZERO, rd);
        end
        apb(1'b0, A_CTRL, DATA_ZERO, 4'h0);
        chk("ctrl", exp_ctrl(ctrl), rd);
        complete_run();
    end
endmodule // test_pcs_control_status_regs
